// ===== core/cbl_unit.sv
// Condition-register logical instruction execution unit
//
// Function
// - Group is primary opcode 19 in bits 0-5; destination index in 6-10.
// - Source A index in bits 11-15, source B in 16-20; bit 31 ignored.
// - AND writes source A AND source B to the destination bit.
// - Extended opcode 129 writes A AND NOT B.
// - Extended opcode 289 writes NOT (A XOR B).
// - Extended opcode 225 writes NOT (A AND B).
// - Extended opcode 33 writes NOT (A OR B).
// - Extended opcode 449 writes A OR B.
// - Fixed-point exception register never altered; single form only.
// - Extended opcode 417 writes A OR NOT B.
// - Extended opcode 193 writes A XOR B.
`timescale 1ns/1ps

module cbl_unit
	import cbl_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Instruction from decode
	input  wire logic        instrValid,
	input  wire logic [31:0] instrWord,
	// Committed condition register value
	input  wire logic [31:0] crIn,
	// Condition register write back
	output logic             crWrEn,
	output logic [31:0]      crWrData,
	output logic [4:0]       crDestIdx,
	// Status
	output logic             illegalOp,
	output logic             xerWrEn
);

	logic [5:0]  primOpcode;
	logic [4:0]  destBitIdx;
	logic [4:0]  srcABitIdx;
	logic [4:0]  srcBBitIdx;
	logic [9:0]  extOpcode;
	logic        isGroup;
	logic [31:0] crEff;
	logic        srcA;
	logic        srcB;
	logic        opResult;
	logic        opKnown;
	logic        accept;
	logic [31:0] newCr;

	logic        crWrEn_q;
	logic        crWrEn_d;
	logic [31:0] crWrData_q;
	logic [31:0] crWrData_d;
	logic [4:0]  crDestIdx_q;
	logic        illegalOp_q;
	logic        illegalOp_d;
	logic        xerWrEn_q;

	// Field extraction, the last word bit is never looked at
	assign primOpcode = instrWord[OPC_MSB:OPC_LSB];
	assign destBitIdx = instrWord[DST_MSB:DST_LSB];
	assign srcABitIdx = instrWord[SRCA_MSB:SRCA_LSB];
	assign srcBBitIdx = instrWord[SRCB_MSB:SRCB_LSB];
	assign extOpcode  = instrWord[XO_MSB:XO_LSB];
	assign isGroup    = instrValid && (primOpcode == OPC_CRLOGIC);

	// Forward our own last write so back-to-back ops see it
	assign crEff = crWrEn_q ? crWrData_q : crIn;

	// Both sources read from the old value before any update
	assign srcA = crBit(crEff, srcABitIdx);
	assign srcB = crBit(crEff, srcBBitIdx);

	// Logic function evaluation
	cbl_op_eval u_eval (
		.extOpcode (extOpcode),
		.srcA      (srcA),
		.srcB      (srcB),
		.result    (opResult),
		.known     (opKnown)
	);

	// Merge the result into the destination bit only
	assign accept = isGroup && opKnown;
	always_comb begin
		newCr = crEff & ~crMask(destBitIdx);
		if (opResult) begin
			newCr = newCr | crMask(destBitIdx);
		end
	end

	// Next write-back values
	assign crWrEn_d    = accept;
	assign crWrData_d  = accept ? newCr : crWrData_q;
	assign illegalOp_d = isGroup && !opKnown;

	// Write-back register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			crWrEn_q   <= 1'b0;
			crWrData_q <= CR_DATA_RST;
		end else begin
			crWrEn_q   <= crWrEn_d;
			crWrData_q <= crWrData_d;
		end
	end

	// Destination index, held for the write
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			crDestIdx_q <= IDX_RST;
		end else if (accept) begin
			crDestIdx_q <= destBitIdx;
		end
	end

	// Unknown extended opcode inside the group
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			illegalOp_q <= 1'b0;
		end else begin
			illegalOp_q <= illegalOp_d;
		end
	end

	// Exception register is never written by this group
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			xerWrEn_q <= 1'b0;
		end else begin
			xerWrEn_q <= 1'b0;
		end
	end

	// Outputs straight from flops
	assign crWrEn    = crWrEn_q;
	assign crWrData  = crWrData_q;
	assign crDestIdx = crDestIdx_q;
	assign illegalOp = illegalOp_q;
	assign xerWrEn   = xerWrEn_q;

	// Checks on the datapath
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// Foreign opcodes never write
	property p_foreign;
		instrValid && (primOpcode != OPC_CRLOGIC) |=> !crWrEn && !illegalOp;
	endproperty
	a_foreign: assert property (p_foreign)
		else $error("Foreign opcode caused a write");

	// Destination index taken from its field
	property p_dest;
		accept |=> crWrEn && (crDestIdx == $past(instrWord[DST_MSB:DST_LSB]));
	endproperty
	a_dest: assert property (p_dest)
		else $error("Destination index mismatch");

	// Last word bit has no effect on acceptance, whatever its value
	property p_lastbit;
		isGroup && (extOpcode == XO_OR) |=> crWrEn && !illegalOp;
	endproperty
	a_lastbit: assert property (p_lastbit)
		else $error("Unused bit changed acceptance");

	// AND result
	property p_and;
		accept && (extOpcode == XO_AND) |=>
			crBit(crWrData, $past(destBitIdx)) == ($past(srcA) & $past(srcB));
	endproperty
	a_and: assert property (p_and)
		else $error("AND result wrong");

	// AND with complement result
	property p_andc;
		accept && (extOpcode == XO_ANDC) |=>
			crBit(crWrData, $past(destBitIdx)) == ($past(srcA) & !$past(srcB));
	endproperty
	a_andc: assert property (p_andc)
		else $error("AND-complement result wrong");

	// Equivalence result
	property p_eqv;
		accept && (extOpcode == XO_EQV) |=>
			crBit(crWrData, $past(destBitIdx)) == ($past(srcA) == $past(srcB));
	endproperty
	a_eqv: assert property (p_eqv)
		else $error("Equivalence result wrong");

	// NAND result
	property p_nand;
		accept && (extOpcode == XO_NAND) |=>
			crBit(crWrData, $past(destBitIdx)) == !($past(srcA) && $past(srcB));
	endproperty
	a_nand: assert property (p_nand)
		else $error("NAND result wrong");

	// NOR result
	property p_nor;
		accept && (extOpcode == XO_NOR) |=>
			crBit(crWrData, $past(destBitIdx)) == !($past(srcA) || $past(srcB));
	endproperty
	a_nor: assert property (p_nor)
		else $error("NOR result wrong");

	// OR result
	property p_or;
		accept && (extOpcode == XO_OR) |=>
			crBit(crWrData, $past(destBitIdx)) == ($past(srcA) | $past(srcB));
	endproperty
	a_or: assert property (p_or)
		else $error("OR result wrong");

	// Exception register write stays low
	property p_noxer;
		instrValid |-> ##1 !xerWrEn ##1 !xerWrEn;
	endproperty
	a_noxer: assert property (p_noxer)
		else $error("Exception register written");

	// OR with complement result
	property p_orc;
		accept && (extOpcode == XO_ORC) |=>
			crBit(crWrData, $past(destBitIdx)) == ($past(srcA) | !$past(srcB));
	endproperty
	a_orc: assert property (p_orc)
		else $error("OR-complement result wrong");

	// XOR result
	property p_xor;
		accept && (extOpcode == XO_XOR) |=>
			crBit(crWrData, $past(destBitIdx)) == ($past(srcA) ^ $past(srcB));
	endproperty
	a_xor: assert property (p_xor)
		else $error("XOR result wrong");

	// Forwarded value is the source of the next operation
	property p_forward;
		crWrEn && accept && (srcABitIdx == crDestIdx)
			|-> srcA == crBit(crWrData, crDestIdx);
	endproperty
	a_forward: assert property (p_forward)
		else $error("Previous write not forwarded");

	// Only the destination bit may differ from the old value
	property p_others;
		accept |=> ((crWrData ^ $past(crEff)) & ~crMask(crDestIdx))
			== 32'h0000_0000;
	endproperty
	a_others: assert property (p_others)
		else $error("Non-destination bit changed");

endmodule

// ===== core/cbl_pkg.sv
// Constants and helpers for the condition-bit logic unit
package cbl_pkg;

	// Instruction word fields, bit 31 of the word is field bit 0
	localparam int unsigned OPC_MSB  = 31;
	localparam int unsigned OPC_LSB  = 26;
	localparam int unsigned DST_MSB  = 25;
	localparam int unsigned DST_LSB  = 21;
	localparam int unsigned SRCA_MSB = 20;
	localparam int unsigned SRCA_LSB = 16;
	localparam int unsigned SRCB_MSB = 15;
	localparam int unsigned SRCB_LSB = 11;
	localparam int unsigned XO_MSB   = 10;
	localparam int unsigned XO_LSB   = 1;

	// Primary opcode of the group
	localparam logic [5:0] OPC_CRLOGIC = 6'h13;

	// Extended opcodes
	localparam logic [9:0] XO_AND  = 10'h101;
	localparam logic [9:0] XO_ANDC = 10'h081;
	localparam logic [9:0] XO_EQV  = 10'h121;
	localparam logic [9:0] XO_NAND = 10'h0e1;
	localparam logic [9:0] XO_NOR  = 10'h021;
	localparam logic [9:0] XO_OR   = 10'h1c1;
	localparam logic [9:0] XO_ORC  = 10'h1a1;
	localparam logic [9:0] XO_XOR  = 10'h0c1;

	// Reset values
	localparam logic [31:0] CR_DATA_RST = 32'h0000_0000;
	localparam logic [4:0]  IDX_RST     = 5'h00;

	// Condition bit by index, index 0 is the most significant bit
	function automatic logic crBit(input logic [31:0] cr,
		input logic [4:0] idx);
		crBit = cr[5'h1f - idx];
	endfunction

	// One-hot mask of a condition bit by index
	function automatic logic [31:0] crMask(input logic [4:0] idx);
		crMask = 32'h8000_0000 >> idx;
	endfunction

endpackage

// ===== core/cbl_op_eval.sv
// Logic function evaluator for one pair of condition bits
`timescale 1ns/1ps

module cbl_op_eval
	import cbl_pkg::*;
(
	// Operation select
	input  wire logic [9:0] extOpcode,
	// Source bits
	input  wire logic       srcA,
	input  wire logic       srcB,
	// Result
	output logic            result,
	output logic            known
);

	// Select the logic function from the extended opcode
	always_comb begin
		result = 1'b0;
		known  = 1'b1;
		case (extOpcode)
			XO_AND: begin
				result = srcA & srcB;
			end
			XO_ANDC: begin
				result = srcA & ~srcB;
			end
			XO_EQV: begin
				result = ~(srcA ^ srcB);
			end
			XO_NAND: begin
				result = ~(srcA & srcB);
			end
			XO_NOR: begin
				result = ~(srcA | srcB);
			end
			XO_OR: begin
				result = srcA | srcB;
			end
			XO_ORC: begin
				result = srcA | ~srcB;
			end
			XO_XOR: begin
				result = srcA ^ srcB;
			end
			default: begin
				known = 1'b0; // Not a member of the group
			end
		endcase
	end

endmodule

// ===== tb/cbl_cr_model.sv
// Condition register held on the far side of the unit
`timescale 1ns/1ps

module cbl_cr_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Preload from the bench
	input  wire logic        loadEn,
	input  wire logic [31:0] loadVal,
	// Write back from the unit
	input  wire logic        crWrEn,
	input  wire logic [31:0] crWrData,
	// Committed value
	output logic [31:0]      crIn
);
	logic [31:0] crQ;

	// Preload wins; otherwise commit the unit's whole new word
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			crQ <= 32'h0000_0000;
		end else if (loadEn) begin
			crQ <= loadVal;
		end else if (crWrEn) begin
			crQ <= crWrData;
		end
	end

	// Committed value seen by the unit
	assign crIn = crQ;
endmodule

// ===== tb/test_cbl_unit.sv
// Self-checking bench for the condition-bit logic unit
`timescale 1ns/1ps

module test_cbl_unit;
	logic        clk, reset, instrValid, loadEn, crWrEn, illegalOp;
	logic        xerWrEn, pWr, pIll;
	logic [31:0] instrWord, loadVal, crIn, crWrData, expCr, pCr;
	logic [4:0]  crDestIdx, pDst;
	int          badCount, checksDone;
	logic [9:0]  xoTab [8] = '{10'h101, 10'h081, 10'h121, 10'h0e1,
		10'h021, 10'h1c1, 10'h1a1, 10'h0c1};

	cbl_unit u_cbl_unit (.clk(clk), .reset(reset), .instrValid(instrValid),
		.instrWord(instrWord), .crIn(crIn), .crWrEn(crWrEn),
		.crWrData(crWrData), .crDestIdx(crDestIdx),
		.illegalOp(illegalOp), .xerWrEn(xerWrEn));
	cbl_cr_model u_cbl_cr_model (.clk(clk), .reset(reset), .loadEn(loadEn),
		.loadVal(loadVal), .crWrEn(crWrEn), .crWrData(crWrData),
		.crIn(crIn));

	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Reference result of one operation; known is low for a bad code
	function automatic logic ev(input logic [9:0] x, input logic a, b,
		output logic known);
		known = 1'b1;
		case (x)
			10'h101: ev = a & b;
			10'h081: ev = a & ~b;
			10'h121: ev = ~(a ^ b);
			10'h0e1: ev = ~(a & b);
			10'h021: ev = ~(a | b);
			10'h1c1: ev = a | b;
			10'h1a1: ev = a | ~b;
			10'h0c1: ev = a ^ b;
			default: begin
				ev = 1'b0;
				known = 1'b0;
			end
		endcase
	endfunction

	// Instruction word; the spare low bit is set to show it is ignored
	function automatic logic [31:0] mk(input logic [5:0] op,
		input logic [4:0] d, a, b, input logic [9:0] x);
		mk = {op, d, a, b, x, 1'b1};
	endfunction

	// Comparisons of flags and of words
	task automatic cmpBit(input string n, input logic e, g);
		checksDone++;
		if (g !== e) begin
			badCount++;
			$display("BAD %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic cmpWord(input string n, input logic [31:0] e, g);
		checksDone++;
		if (g !== e) begin
			badCount++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	// Drive one cycle, judge the last instruction, predict this one
	task automatic step(input logic [31:0] w, input logic v);
		logic r, k;
		@(posedge clk);
		instrValid <= v;
		instrWord  <= w;
		@(negedge clk);
		cmpBit("crWrEn", pWr, crWrEn);
		cmpBit("illegalOp", pIll, illegalOp);
		cmpBit("xerWrEn", 1'b0, xerWrEn);
		cmpWord("crWrData", pCr, crWrData);
		cmpWord("crDestIdx", {27'h0, pDst}, {27'h0, crDestIdx});
		r = ev(w[10:1], expCr[31 - w[20:16]], expCr[31 - w[15:11]], k);
		pWr  = v && w[31:26] == 6'h13 && k;
		pIll = v && w[31:26] == 6'h13 && !k;
		if (pWr) begin
			pCr = expCr;
			pCr[31 - w[25:21]] = r;
			pDst = w[25:21];
			expCr = pCr;
		end
	endtask

	// Flush the last result, then preload the register
	task automatic load(input logic [31:0] c);
		step(32'h0, 1'b0);
		@(posedge clk);
		loadEn  <= 1'b1;
		loadVal <= c;
		@(posedge clk);
		loadEn <= 1'b0;
		expCr = c;
	endtask

	// Every code over all four source pairs, extreme indices
	task automatic tAllOps();
		for (int i = 0; i < 8; i++) begin
			for (int c = 0; c < 4; c++) begin
				load({c[1], 30'h1555_5555, c[0]});
				step(mk(6'h13, 5'h1f, 5'h00, 5'h1f, xoTab[i]), 1'b1);
			end
		end
	endtask

	// Chained writes on consecutive cycles use the fresh values
	task automatic tBackToBack();
		load(32'h8000_0001);
		step(mk(6'h13, 5'h05, 5'h00, 5'h1f, 10'h101), 1'b1);
		step(mk(6'h13, 5'h00, 5'h05, 5'h1e, 10'h021), 1'b1);
		step(mk(6'h13, 5'h1f, 5'h00, 5'h05, 10'h1a1), 1'b1);
	endtask

	// Unknown codes, foreign opcodes and idle cycles write nothing; an OR with the spare low bit clear still writes
	task automatic tRefused();
		load(32'h1234_5678);
		step(mk(6'h13, 5'h03, 5'h01, 5'h02, 10'h000), 1'b1);
		step(mk(6'h13, 5'h03, 5'h01, 5'h02, 10'h102), 1'b1);
		step(mk(6'h1f, 5'h03, 5'h01, 5'h02, 10'h101), 1'b1);
		step(mk(6'h13, 5'h03, 5'h01, 5'h02, 10'h101), 1'b0);
		step(mk(6'h13, 5'h03, 5'h01, 5'h02, 10'h1c1) & 32'hffff_fffe,
			1'b1);
		step(32'h0, 1'b0);
	endtask

	// Reset in mid-run clears the write-back outputs after a write
	task automatic tMidReset();
		load(32'hffff_ffff);
		step(mk(6'h13, 5'h02, 5'h00, 5'h01, 10'h101), 1'b1);
		step(32'h0, 1'b0);
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		pWr   = 1'b0;
		pIll  = 1'b0;
		pCr   = 32'h0;
		pDst  = 5'h00;
		expCr = 32'h0;
		step(32'h0, 1'b0);
	endtask

	// Counts and verdict
	task automatic endOfTest();
		$display("checks %0d mismatches %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (3000) @(posedge clk);
		badCount++;
		endOfTest();
	end

	// Main sequence; the first step checks the reset values
	initial begin
		reset      = 1'b1;
		instrValid = 1'b0;
		instrWord  = 32'h0;
		loadEn     = 1'b0;
		loadVal    = 32'h0;
		pWr        = 1'b0;
		pIll       = 1'b0;
		pCr        = 32'h0;
		pDst       = 5'h00;
		expCr      = 32'h0;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		step(32'h0, 1'b0);
		tAllOps();
		tBackToBack();
		tRefused();
		tMidReset();
		endOfTest();
	end
endmodule
